//--- hw/sto_interlock.sv
`timescale 1ns/1ps
`default_nettype none
`include "sto_defines.svh"
module sto_interlock (
    input wire logic clk_in, // 20 MHz system clock
    input wire logic rst_n_in, // async reset, active low
    input wire logic general_input_3_in, // pin, line A when enabled
    input wire logic general_input_4_in, // pin, line B when enabled
    input wire logic jumper_enable_in, // high when jumper removed
    input wire logic kill_feedback_in, // pin, high while gate kill path is cut
    input wire logic [`STO_PHASE_GATES-1:0] phase_gate_in, // gate commands from controller
    output logic [`STO_PHASE_GATES-1:0] phase_gate_out, // gate drive to power stage
    output logic stage_enable_out, // power stage may be energized
    output logic kill_test_out, // forces gate kill during self-check
    output logic general_input_3_out, // ordinary input 3, zero when taken
    output logic general_input_4_out, // ordinary input 4, zero when taken
    output logic torque_off_enabled_out, // function enabled by jumper
    output logic check_busy_out, // self-check running
    output logic check_fail_out, // last self-check failed
    output logic mismatch_fault_out // exactly one line high while enabled
);
    // ----------------------------------------
    // input synchronisers
    // ----------------------------------------
    logic [`STO_SYNC_N-1:0] raw;
    logic [`STO_SYNC_N-1:0] syn;

    assign raw = {kill_feedback_in, jumper_enable_in, general_input_4_in, general_input_3_in};

    genvar gi;
    generate
        for (gi = 0; gi < `STO_SYNC_N; gi = gi + 1) begin : g_sync
            sto_sync u_sync (
                .clk_in(clk_in),
                .rst_n_in(rst_n_in),
                .pin_in(raw[gi]),
                .level_out(syn[gi])
            );
        end
    endgenerate

    logic en;
    logic line_a;
    logic line_b;
    logic both_high;
    logic fb;

    assign en = syn[`STO_SYNC_JMP]; // see R9
    assign line_a = syn[`STO_SYNC_IN3]; // see R1
    assign line_b = syn[`STO_SYNC_IN4]; // see R1
    assign both_high = line_a & line_b;
    assign fb = syn[`STO_SYNC_FB];

    // ----------------------------------------
    // self-check sequencer
    // ----------------------------------------
    sto_pkg::sto_state_type state;
    sto_pkg::sto_state_type next_state;
    logic prev_both;
    logic [`STO_CNT_W-1:0] cnt;
    logic check_ok;
    logic check_done;
    logic entry;

    localparam logic [`STO_CNT_W-1:0] CHECK_LAST = `STO_CNT_W'(`STO_CHECK_CYCLES - 1);

    // prev_both is cleared while disabled so that enabling with both high also checks
    assign entry = both_high & ~prev_both; // see R4
    assign check_done = (cnt == CHECK_LAST);

    always_comb begin
        next_state = state;
        case (state)
            sto_pkg::STO_OFF: begin
                if (en && entry) begin
                    next_state = sto_pkg::STO_CHECK; // see R3
                end
            end
            sto_pkg::STO_CHECK: begin
                if (!en || !both_high) begin
                    next_state = sto_pkg::STO_OFF;
                end else if (check_done) begin
                    next_state = (check_ok && fb) ? sto_pkg::STO_RUN : sto_pkg::STO_OFF; // see R5
                end
            end
            sto_pkg::STO_RUN: begin
                if (!en || !both_high) begin
                    next_state = sto_pkg::STO_OFF; // see R6
                end
            end
            default: begin
                next_state = sto_pkg::STO_OFF;
            end
        endcase
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state <= sto_pkg::STO_OFF;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            prev_both <= 1'h0; // power-on counts as an entry into both-high
        end else begin
            prev_both <= en & both_high;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cnt <= `STO_CNT_RST;
        end else if (state == sto_pkg::STO_CHECK && !check_done) begin
            cnt <= cnt + `STO_CNT_W'(1);
        end else begin
            cnt <= `STO_CNT_RST;
        end
    end

    // the kill path must read back as cut on every cycle of the check,
    // once the test drive has had time to return through the pin filter
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            check_ok <= 1'h0;
        end else if (state != sto_pkg::STO_CHECK) begin
            check_ok <= 1'h1;
        end else if (!fb && cnt >= `STO_FB_GRACE) begin
            check_ok <= 1'h0;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            check_fail_out <= 1'h0;
        end else if (state == sto_pkg::STO_CHECK && next_state == sto_pkg::STO_OFF
                && check_done) begin
            check_fail_out <= 1'h1;
        end else if (next_state == sto_pkg::STO_RUN) begin
            check_fail_out <= 1'h0;
        end
    end

    // ----------------------------------------
    // output gating
    // ----------------------------------------
    logic allow;
    logic run_ok;
    logic [2:0] settle;
    logic settled;

    // the filtered jumper reads low until the filters fill, which would pass as a
    // disabled function; gates stay off until every filter holds a real level
    assign settled = (settle == `STO_SETTLE_LAST);

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            settle <= `STO_SETTLE_RST;
        end else if (!settled) begin
            settle <= settle + 3'h1;
        end
    end

    // no other input can lift the kill: controller faults only reach the gates via allow
    assign run_ok = (state == sto_pkg::STO_RUN) & both_high;
    assign allow = settled & (~en | run_ok); // see R2, R3, R7, R11

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            phase_gate_out <= `STO_GATES_RST;
            stage_enable_out <= 1'h0;
        end else begin
            // every switch off, never a braking pattern
            phase_gate_out <= allow ? phase_gate_in : `STO_GATES_RST; // see R8
            stage_enable_out <= allow;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            kill_test_out <= 1'h0;
            check_busy_out <= 1'h0;
        end else begin
            kill_test_out <= (next_state == sto_pkg::STO_CHECK);
            check_busy_out <= (next_state == sto_pkg::STO_CHECK);
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            general_input_3_out <= 1'h0;
            general_input_4_out <= 1'h0;
            torque_off_enabled_out <= 1'h0;
            mismatch_fault_out <= 1'h0;
        end else begin
            general_input_3_out <= line_a & ~en; // see R1, R11
            general_input_4_out <= line_b & ~en; // see R1, R11
            torque_off_enabled_out <= en;
            mismatch_fault_out <= en & (line_a ^ line_b); // see R10
        end
    end

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    // helper state: cycles spent in the current check, and a kill-path miss seen in it
    logic [8:0] check_span;
    logic fail_seen;

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            check_span <= 9'h000;
        end else if (state == sto_pkg::STO_CHECK) begin
            check_span <= check_span + 9'h001;
        end else begin
            check_span <= 9'h000;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            fail_seen <= 1'h0;
        end else if (state != sto_pkg::STO_CHECK) begin
            fail_seen <= 1'h0;
        end else if (!fb && cnt >= `STO_FB_GRACE) begin
            fail_seen <= 1'h1;
        end
    end

    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!rst_n_in);

    a_line_low_off: assert property (en && !both_high |=> // see R6
        phase_gate_out == `STO_GATES_RST && !stage_enable_out)
        else $error("gates live while a line is low");
    a_run_needs_check: assert property (en && state != sto_pkg::STO_RUN |=> // see R5
        !stage_enable_out)
        else $error("stage enabled without a passed check");
    a_entry_starts: assert property (en && state == sto_pkg::STO_OFF && entry |=> // see R4
        state == sto_pkg::STO_CHECK && kill_test_out)
        else $error("entry into both-high did not start a check");
    a_check_length: assert property (state == sto_pkg::STO_RUN // see R3
        && check_span != 9'h000 |-> check_span == 9'(`STO_CHECK_CYCLES))
        else $error("check finished early");
    a_check_pass: assert property (state == sto_pkg::STO_CHECK && check_done // see R5
        && check_ok && fb && en && both_high
        |=> state == sto_pkg::STO_RUN ##1 (stage_enable_out || !$past(both_high)))
        else $error("passed check did not release outputs");
    a_fail_hold: assert property (fail_seen |-> state != sto_pkg::STO_RUN) // see R3
        else $error("failed check released outputs");
    a_mismatch_flag: assert property (en && (line_a != line_b) |=> // see R10
        mismatch_fault_out && !stage_enable_out)
        else $error("mismatch not flagged");
    a_disabled_pass: assert property (!en && settled |=> // see R11
        phase_gate_out == $past(phase_gate_in) && stage_enable_out)
        else $error("disabled function touched outputs");
    a_inputs_taken: assert property (en |=> // see R1
        !general_input_3_out && !general_input_4_out)
        else $error("lines still seen as general inputs");
    a_startup_off: assert property (!settled |=> !stage_enable_out) // see R3
        else $error("stage enabled before filters settled");

    c_check_pass: cover property (state == sto_pkg::STO_CHECK ##1 state == sto_pkg::STO_RUN);
    c_check_fail: cover property ($rose(check_fail_out));
    c_mismatch: cover property ($rose(mismatch_fault_out));
    c_run_drop: cover property (state == sto_pkg::STO_RUN ##1 state == sto_pkg::STO_OFF);
endmodule
`default_nettype wire

//--- hw/sto_defines.svh
`ifndef STO_DEFINES_SVH
`define STO_DEFINES_SVH
// How it works
// R1: enabled: inputs 3 and 4 become lines A, B
// R2: energize only while both lines are high
// R3: self-check after every power-on reset
// R4: fresh self-check on every entry into both-high
// R5: outputs held off until latest check passed
// R6: either line low disables outputs at once
// R7: torque-off overrides every other control path
// R8: all phase switches off, motor floats, no braking
// R9: function off by default, jumper input enables
// R10: one line high only raises mismatch fault
// R11: disabled: lines are plain inputs, no effect

// ----------------------------------------
// clock and timing
// ----------------------------------------
`define STO_CLK_MHZ 20
`define STO_CHECK_TIME_NS 10000
`define STO_CHECK_CYCLES ((`STO_CHECK_TIME_NS * `STO_CLK_MHZ) / 1000)
`define STO_FB_GRACE 8'h04
`define STO_SETTLE_LAST 3'h5

// ----------------------------------------
// widths and field positions
// ----------------------------------------
`define STO_PHASE_GATES 6
`define STO_CNT_W 8
`define STO_SYNC_N 4
`define STO_SYNC_IN3 0
`define STO_SYNC_IN4 1
`define STO_SYNC_JMP 2
`define STO_SYNC_FB 3

// ----------------------------------------
// reset values
// ----------------------------------------
`define STO_GATES_RST 6'h00
`define STO_CNT_RST 8'h00
`define STO_SETTLE_RST 3'h0
`endif

//--- hw/sto_pkg.sv
package sto_pkg;
    typedef enum logic [2:0] {
        STO_OFF = 3'h1,
        STO_CHECK = 3'h2,
        STO_RUN = 3'h4
    } sto_state_type;
endpackage

//--- hw/sto_sync.sv
`timescale 1ns/1ps
`default_nettype none
// three-stage synchroniser; output moves only once stages two and three agree
module sto_sync (
    input wire logic clk_in, // system clock
    input wire logic rst_n_in, // async reset, active low
    input wire logic pin_in, // asynchronous pin level
    output logic level_out // filtered level
);
    logic s1;
    logic s2;
    logic s3;

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            s1 <= 1'h0;
            s2 <= 1'h0;
            s3 <= 1'h0;
        end else begin
            s1 <= pin_in;
            s2 <= s1;
            s3 <= s2;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            level_out <= 1'h0;
        end else if (s2 == s3) begin
            level_out <= s3;
        end
    end
endmodule
`default_nettype wire

//--- tb/sto_switch_model.sv
`timescale 1ns/1ps
`default_nettype none
module sto_switch_model (
    input wire logic clk_in, // system clock
    input wire logic want_a_in, // requested level of line a
    input wire logic want_b_in, // requested level of line b
    input wire logic kill_test_in, // kill request from the interlock
    input wire logic break_fb_in, // high fakes a kill path that never cuts
    output logic line_a_out, // torque-off line a
    output logic line_b_out, // torque-off line b
    output logic kill_feedback_out // high while kill path is cut
);
    // ----------------------------------------
    // lines and kill path
    // ----------------------------------------
    // the relay lets go slowly: the path still reads cut for a while after both lines rise
    logic [3:0] hold = 4'hF;
    assign line_a_out = want_a_in;
    assign line_b_out = want_b_in;
    always_ff @(posedge clk_in) begin
        if (!(want_a_in && want_b_in)) begin
            hold <= 4'hF;
        end else if (hold != 4'h0) begin
            hold <= hold - 4'h1;
        end
    end
    assign kill_feedback_out = ~break_fb_in & (kill_test_in | (hold != 4'h0));
endmodule
`default_nettype wire

//--- tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic clk_in = 1'h0, rst_n_in = 1'h0, want_a = 1'h0, want_b = 1'h0;
    logic jumper = 1'h0, break_fb = 1'h0;
    logic [5:0] gate_cmd = 6'h2D;
    wire logic line_a, line_b, fb, stage_en, kill_test, gi3, gi4, en_o, busy, fail, mism;
    wire logic [5:0] gate_out;
    int errors = 0, checks = 0;
    initial forever #25 clk_in = ~clk_in;
    sto_interlock sto_interlock_i (.clk_in(clk_in), .rst_n_in(rst_n_in),
        .general_input_3_in(line_a), .general_input_4_in(line_b),
        .jumper_enable_in(jumper), .kill_feedback_in(fb), .phase_gate_in(gate_cmd),
        .phase_gate_out(gate_out), .stage_enable_out(stage_en), .kill_test_out(kill_test),
        .general_input_3_out(gi3), .general_input_4_out(gi4),
        .torque_off_enabled_out(en_o), .check_busy_out(busy),
        .check_fail_out(fail), .mismatch_fault_out(mism));
    sto_switch_model sto_switch_model_i (.clk_in(clk_in), .want_a_in(want_a),
        .want_b_in(want_b), .kill_test_in(kill_test), .break_fb_in(break_fb),
        .line_a_out(line_a), .line_b_out(line_b), .kill_feedback_out(fb));
    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("unexpected %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk_in);
    endtask
    // bounded wait; an aborted or failed check also ends it
    task automatic wait_idle;
        int k;
        k = 0;
        while (busy !== 1'h0 && k < 400) begin
            cyc(1);
            k++;
        end
        cyc(2);
    endtask
    task automatic summarize;
        if (errors == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_disabled;
        want_a = 1'h1;
        cyc(8);
        chk("en", 8'h00, {7'h00, en_o});
        chk("gi3", 8'h01, {7'h00, gi3});
        chk("gi4", 8'h00, {7'h00, gi4});
        chk("mism", 8'h00, {7'h00, mism});
        chk("stage", 8'h01, {7'h00, stage_en});
        chk("gates", {2'h0, gate_cmd}, {2'h0, gate_out});
        want_a = 1'h0;
    endtask
    task automatic t_check_pass;
        jumper = 1'h1;
        cyc(8);
        chk("en", 8'h01, {7'h00, en_o});
        chk("gates off", 8'h00, {2'h0, gate_out});
        want_a = 1'h1;
        want_b = 1'h1;
        cyc(6);
        chk("busy", 8'h01, {7'h00, busy});
        chk("kill", 8'h01, {7'h00, kill_test});
        chk("gi3", 8'h00, {7'h00, gi3});
        chk("gi4", 8'h00, {7'h00, gi4});
        cyc(190);
        chk("busy late", 8'h01, {7'h00, busy});
        chk("stage early", 8'h00, {7'h00, stage_en});
        chk("gates early", 8'h00, {2'h0, gate_out});
        wait_idle();
        chk("stage", 8'h01, {7'h00, stage_en});
        chk("gates", {2'h0, gate_cmd}, {2'h0, gate_out});
        chk("fail", 8'h00, {7'h00, fail});
    endtask
    task automatic t_drop;
        gate_cmd = 6'h3F;
        want_b = 1'h0;
        cyc(6);
        chk("gates drop", 8'h00, {2'h0, gate_out});
        chk("stage drop", 8'h00, {7'h00, stage_en});
        chk("mism", 8'h01, {7'h00, mism});
        want_a = 1'h0;
        cyc(6);
        chk("mism low", 8'h00, {7'h00, mism});
        chk("gates low", 8'h00, {2'h0, gate_out});
        want_b = 1'h1;
        cyc(6);
        chk("mism b", 8'h01, {7'h00, mism});
        chk("stage mism b", 8'h00, {7'h00, stage_en});
        want_a = 1'h1;
        cyc(6);
        chk("busy again", 8'h01, {7'h00, busy});
        wait_idle();
        chk("stage again", 8'h01, {7'h00, stage_en});
    endtask
    task automatic t_bad_path;
        want_a = 1'h0;
        want_b = 1'h0;
        break_fb = 1'h1;
        cyc(6);
        want_a = 1'h1;
        want_b = 1'h1;
        cyc(6);
        wait_idle();
        chk("fail", 8'h01, {7'h00, fail});
        chk("stage bad", 8'h00, {7'h00, stage_en});
        chk("gates bad", 8'h00, {2'h0, gate_out});
        break_fb = 1'h0;
        want_a = 1'h0;
        cyc(6);
        want_a = 1'h1;
        cyc(6);
        wait_idle();
        chk("fail cleared", 8'h00, {7'h00, fail});
        chk("stage ok", 8'h01, {7'h00, stage_en});
    endtask
    // reset in mid-run with the function enabled and both lines high
    task automatic t_reset;
        int k;
        rst_n_in = 1'h0;
        cyc(3);
        rst_n_in = 1'h1;
        for (k = 0; k < 8; k++) begin
            cyc(1);
            chk("stage at reset", 8'h00, {7'h00, stage_en});
        end
        chk("gates at reset", 8'h00, {2'h0, gate_out});
        chk("busy at reset", 8'h01, {7'h00, busy});
        wait_idle();
        chk("stage after reset", 8'h01, {7'h00, stage_en});
        chk("fail after reset", 8'h00, {7'h00, fail});
    endtask
    initial begin
        cyc(3);
        rst_n_in = 1'h1;
        t_disabled();
        t_check_pass();
        t_drop();
        t_bad_path();
        t_reset();
        summarize();
    end
    // runs need about 1100 cycles
    initial begin
        repeat (4000) @(posedge clk_in);
        errors++;
        summarize();
    end
endmodule
`default_nettype wire
